// ### hw/fanout_pkg.sv
// Shared constants and types for the clock fan-out output-enable block
package fanout_pkg;

  localparam int NUM_OUT = 14;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 4;

  // Seven-bit serial address of the device, write direction only
  localparam logic [6:0] DEV_ADDR = 7'h69;
  localparam logic DIR_WRITE = 1'h0;

  // Bit slot holding the acknowledge clock inside each nine-clock byte
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Byte index of each configuration byte; IDX_PAST marks bytes beyond the map
  localparam logic [1:0] IDX_LOW = 2'h0;
  localparam logic [1:0] IDX_MID = 2'h1;
  localparam logic [1:0] IDX_HIGH = 2'h2;
  localparam logic [1:0] IDX_PAST = 2'h3;

  // Power-up values: every output bit set, reserved bits clear
  localparam logic [7:0] LOW_RESET = 8'hCF;
  localparam logic [7:0] MID_RESET = 8'hF3;
  localparam logic [7:0] HIGH_RESET = 8'hC0;
  localparam logic [13:0] EN_RESET = 14'h3FFF;

  // Source of each output enable in the joined {high, mid, low} byte vector
  localparam logic [4:0] OUT_SRC [NUM_OUT] = '{
    5'h00, 5'h01, 5'h02, 5'h03, 5'h06, 5'h07, 5'h08,
    5'h09, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h16, 5'h17
  };

  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_IGNORE} link_state_t;

endpackage : fanout_pkg

// ### hw/serial_byte_rx.sv
// Serial link side: shifts bits on the serial clock and flags a full byte
`timescale 1ns/1ps
module serial_byte_rx (
  input wire logic link_clk,
  input wire logic frame_clr,
  input wire logic config_serial_data_in,
  output logic [7:0] rx_byte,
  output logic byte_full
);

  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;

  always_comb begin
    nxt_cnt = cnt_ff + 4'h1;
    nxt_shift = shift_ff;
    if (cnt_ff == fanout_pkg::ACK_SLOT) begin
      nxt_cnt = 4'h0;
    end else begin
      // First bit taken is bit 7, last is bit 0
      nxt_shift = {shift_ff[6:0], config_serial_data_in};
    end
  end

  // The serial clock stops between frames, so the start of a frame clears
  // the counter asynchronously from a flop in the main clock domain.
  always_ff @(posedge link_clk or posedge frame_clr) begin
    if (frame_clr) begin
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
    end else begin
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
    end
  end

  // Held from the eighth data edge to the acknowledge edge; the byte is stable meanwhile
  assign byte_full = (cnt_ff == fanout_pkg::ACK_SLOT);
  assign rx_byte = shift_ff;

endmodule : serial_byte_rx

// ### hw/clock_gate_bank.sv
// Per-output clock gating and shared three-state control on the buffered input clock
`timescale 1ns/1ps
module clock_gate_bank #(
  parameter int NUM_OUT = 14
) (
  input wire logic buf_in,
  input wire logic out_drive_en,
  input wire logic [NUM_OUT-1:0] out_en,
  output logic [NUM_OUT-1:0] clk_out,
  output logic [NUM_OUT-1:0] clk_out_oe
);

  logic drv_s1;
  logic drv_s2;

  // Drive enable pin passes two flops; both sample on the falling input edge
  always_ff @(negedge buf_in) begin
    drv_s1 <= out_drive_en;
    drv_s2 <= drv_s1;
  end

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    logic en_s1;
    logic en_s2;
    // Enable changes only while the input clock is low, so no runt pulses
    always_ff @(negedge buf_in) begin
      en_s1 <= out_en[i];
      en_s2 <= en_s1;
    end
    assign clk_out[i] = buf_in & en_s2;
    assign clk_out_oe[i] = drv_s2;

    // Checked on the falling edge, where the input clock still samples high
    property p_gate_low;
      @(negedge buf_in) !en_s2 |-> !clk_out[i];
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("Disabled output not low");

    property p_follow;
      @(negedge buf_in) en_s2 |-> clk_out[i];
    endproperty
    a_follow: assert property (p_follow) else $error("Enabled output misses clock");

    property p_hiz;
      @(negedge buf_in) !$past(out_drive_en, 2) |-> !clk_out_oe[i];
    endproperty
    a_hiz: assert property (p_hiz) else $error("Output driven with pin low");
  end

endmodule : clock_gate_bank

// ### hw/clock_fanout_output_enable_control.sv
// Top of the clock fan-out buffer with serially written output enables
`timescale 1ns/1ps
module clock_fanout_output_enable_control #(
  parameter int NUM_OUT = 14
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic buf_in,
  input wire logic out_drive_en,
  input wire logic config_serial_clock,
  input wire logic config_serial_data_in,
  output logic config_serial_data_out,
  output logic config_serial_data_oe,
  output logic [NUM_OUT-1:0] clk_out,
  output logic [NUM_OUT-1:0] clk_out_oe
);

  // Synchronisers for watching the serial pins and the byte-full flag from the main clock
  logic sclk_q1_ff;
  logic sclk_q2_ff;
  logic sclk_q3_ff;
  logic sda_q1_ff;
  logic sda_q2_ff;
  logic sda_q3_ff;
  logic full_q1_ff;
  logic full_q2_ff;
  logic full_q3_ff;

  logic [7:0] rx_byte;
  logic byte_full;

  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_q1_ff <= 1'b1;
      sclk_q2_ff <= 1'b1;
      sclk_q3_ff <= 1'b1;
      sda_q1_ff <= 1'b1;
      sda_q2_ff <= 1'b1;
      sda_q3_ff <= 1'b1;
      full_q1_ff <= 1'b0;
      full_q2_ff <= 1'b0;
      full_q3_ff <= 1'b0;
    end else begin
      sclk_q1_ff <= config_serial_clock;
      sclk_q2_ff <= sclk_q1_ff;
      sclk_q3_ff <= sclk_q2_ff;
      sda_q1_ff <= config_serial_data_in;
      sda_q2_ff <= sda_q1_ff;
      sda_q3_ff <= sda_q2_ff;
      full_q1_ff <= byte_full;
      full_q2_ff <= full_q1_ff;
      full_q3_ff <= full_q2_ff;
    end
  end

  logic start_seen;
  logic stop_seen;
  logic commit;

  // Data moving while the serial clock is high frames a transfer
  assign start_seen = sclk_q2_ff && sclk_q3_ff && sda_q3_ff && !sda_q2_ff;
  assign stop_seen = sclk_q2_ff && sclk_q3_ff && !sda_q3_ff && sda_q2_ff;
  assign commit = full_q2_ff && !full_q3_ff;

  // Link state and acknowledge driver
  fanout_pkg::link_state_t state_ff;
  fanout_pkg::link_state_t nxt_state;
  logic [1:0] idx_ff;
  logic [1:0] nxt_idx;
  logic frame_clr_ff;
  logic nxt_frame_clr;
  logic addr_phase_ff;
  logic nxt_addr_phase;
  logic addressed_ff;
  logic nxt_addressed;
  logic ack_oe_ff;
  logic nxt_ack_oe;
  logic [7:0] low_ff;
  logic [7:0] nxt_low;
  logic [7:0] mid_ff;
  logic [7:0] nxt_mid;
  logic [7:0] high_ff;
  logic [7:0] nxt_high;
  logic addr_match;

  assign addr_match = (rx_byte == {fanout_pkg::DEV_ADDR, fanout_pkg::DIR_WRITE});

  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_frame_clr = frame_clr_ff;
    nxt_low = low_ff;
    nxt_mid = mid_ff;
    nxt_high = high_ff;
    if (start_seen) begin
      // A repeated start restarts framing and drops a pending answer
      nxt_state = fanout_pkg::ST_ADDR;
      nxt_frame_clr = 1'b1;
    end else if (stop_seen) begin
      nxt_state = fanout_pkg::ST_IDLE;
      nxt_frame_clr = 1'b1;
    end else begin
      // Release the link counter only once the serial clock is low
      if (state_ff != fanout_pkg::ST_IDLE && !sclk_q2_ff) begin
        nxt_frame_clr = 1'b0;
      end
      if (commit) begin
        case (state_ff)
          fanout_pkg::ST_ADDR: begin
            if (addr_match) begin
              nxt_state = fanout_pkg::ST_DATA;
              nxt_idx = fanout_pkg::IDX_LOW;
            end else begin
              nxt_state = fanout_pkg::ST_IGNORE;
            end
          end
          fanout_pkg::ST_DATA: begin
            // Ascending byte order; bytes past the map are taken and dropped
            if (idx_ff != fanout_pkg::IDX_PAST) begin
              nxt_idx = idx_ff + 2'h1;
            end
            if (idx_ff == fanout_pkg::IDX_LOW) begin
              nxt_low = rx_byte;
            end else if (idx_ff == fanout_pkg::IDX_MID) begin
              nxt_mid = rx_byte;
            end else if (idx_ff == fanout_pkg::IDX_HIGH) begin
              nxt_high = rx_byte;
            end
          end
          default: begin
            nxt_state = state_ff;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= fanout_pkg::ST_IDLE;
      idx_ff <= fanout_pkg::IDX_LOW;
      frame_clr_ff <= 1'b1;
      low_ff <= fanout_pkg::LOW_RESET;
      mid_ff <= fanout_pkg::MID_RESET;
      high_ff <= fanout_pkg::HIGH_RESET;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      frame_clr_ff <= nxt_frame_clr;
      low_ff <= nxt_low;
      mid_ff <= nxt_mid;
      high_ff <= nxt_high;
    end
  end

  // Reserved bits are stored but steer nothing, so a careless host is harmless
  logic [23:0] cfg_bits;
  logic [NUM_OUT-1:0] en_ff;
  logic [NUM_OUT-1:0] nxt_en;

  assign cfg_bits = {high_ff, mid_ff, low_ff};

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_map
    assign nxt_en[i] = cfg_bits[fanout_pkg::OUT_SRC[i]];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      en_ff <= fanout_pkg::EN_RESET;
    end else begin
      en_ff <= nxt_en;
    end
  end

  // The acknowledge pulls the line low; the pin never drives high
  always_ff @(posedge clock) begin
    if (rst) begin
      config_serial_data_out <= 1'b0;
    end else begin
      config_serial_data_out <= 1'b0;
    end
  end

  // Link-side answer: at the full serial rate the main clock cannot place the
  // acknowledge inside one low phase, so it is decided on the link clock.
  always_comb begin
    nxt_addr_phase = addr_phase_ff;
    nxt_addressed = addressed_ff;
    if (byte_full) begin
      nxt_addr_phase = 1'b0;
      if (addr_phase_ff) begin
        nxt_addressed = addr_match;
      end
    end
  end

  always_ff @(posedge config_serial_clock or posedge frame_clr_ff) begin
    if (frame_clr_ff) begin
      addr_phase_ff <= 1'b1;
      addressed_ff <= 1'b0;
    end else begin
      addr_phase_ff <= nxt_addr_phase;
      addressed_ff <= nxt_addressed;
    end
  end

  // Raised on the fall after the eighth bit, dropped on the fall after the ninth
  always_comb begin
    nxt_ack_oe = 1'b0;
    if (byte_full && addr_phase_ff) begin
      nxt_ack_oe = addr_match;
    end else if (byte_full) begin
      nxt_ack_oe = addressed_ff;
    end
  end

  always_ff @(negedge config_serial_clock or posedge frame_clr_ff) begin
    if (frame_clr_ff) begin
      ack_oe_ff <= 1'b0;
    end else begin
      ack_oe_ff <= nxt_ack_oe;
    end
  end
  assign config_serial_data_oe = ack_oe_ff;

  serial_byte_rx u_rx (
    .link_clk(config_serial_clock),
    .frame_clr(frame_clr_ff),
    .config_serial_data_in(config_serial_data_in),
    .rx_byte(rx_byte),
    .byte_full(byte_full)
  );

  clock_gate_bank #(
    .NUM_OUT(NUM_OUT)
  ) u_gate (
    .buf_in(buf_in),
    .out_drive_en(out_drive_en),
    .out_en(en_ff),
    .clk_out(clk_out),
    .clk_out_oe(clk_out_oe)
  );

  sequence s_data_commit(logic [1:0] at);
    commit && !start_seen && !stop_seen && state_ff == fanout_pkg::ST_DATA && idx_ff == at;
  endsequence

  property p_power_on;
    @(posedge clock) rst |=> en_ff == fanout_pkg::EN_RESET && low_ff == fanout_pkg::LOW_RESET;
  endproperty
  a_power_on: assert property (p_power_on) else $error("Enables not all set after reset");

  property p_addr_ok;
    @(posedge clock) disable iff (rst)
      commit && !start_seen && !stop_seen && state_ff == fanout_pkg::ST_ADDR && addr_match
      |=> state_ff == fanout_pkg::ST_DATA && idx_ff == fanout_pkg::IDX_LOW;
  endproperty
  a_addr_ok: assert property (p_addr_ok) else $error("Own address not accepted");

  property p_addr_bad;
    @(posedge clock) disable iff (rst)
      commit && !start_seen && !stop_seen && state_ff == fanout_pkg::ST_ADDR && !addr_match
      |=> state_ff == fanout_pkg::ST_IGNORE && $stable(idx_ff);
  endproperty
  a_addr_bad: assert property (p_addr_bad) else $error("Foreign address accepted");

  property p_low_map;
    @(posedge clock) disable iff (rst)
      s_data_commit(fanout_pkg::IDX_LOW) |=> ##1
      en_ff[5] == $past(rx_byte[7], 2) && en_ff[4] == $past(rx_byte[6], 2) && en_ff[0] == $past(rx_byte[0], 2);
  endproperty
  a_low_map: assert property (p_low_map) else $error("Byte zero mapped wrongly");

  property p_mid_map;
    @(posedge clock) disable iff (rst)
      s_data_commit(fanout_pkg::IDX_MID) |=> ##1
      en_ff[11] == $past(rx_byte[7], 2) && en_ff[8] == $past(rx_byte[4], 2) && en_ff[7] == $past(rx_byte[1], 2);
  endproperty
  a_mid_map: assert property (p_mid_map) else $error("Byte one mapped wrongly");

  property p_high_map;
    @(posedge clock) disable iff (rst)
      s_data_commit(fanout_pkg::IDX_HIGH) |=> ##1
      en_ff[13] == $past(rx_byte[7], 2) && en_ff[12] == $past(rx_byte[6], 2);
  endproperty
  a_high_map: assert property (p_high_map) else $error("Byte two mapped wrongly");

  property p_order;
    @(posedge clock) disable iff (rst)
      s_data_commit(fanout_pkg::IDX_LOW) |=> idx_ff == fanout_pkg::IDX_MID;
  endproperty
  a_order: assert property (p_order) else $error("Byte index did not advance");

  property p_only_on_write;
    @(posedge clock) disable iff (rst)
      $changed(low_ff) |-> $past(commit) && $past(state_ff) == fanout_pkg::ST_DATA;
  endproperty
  a_only_on_write: assert property (p_only_on_write) else $error("Enable byte changed unbidden");

  property p_ack_ends;
    @(negedge config_serial_clock) disable iff (frame_clr_ff)
      ack_oe_ff |=> !ack_oe_ff;
  endproperty
  a_ack_ends: assert property (p_ack_ends) else $error("Acknowledge held past one clock");

  property p_ack_foreign;
    @(negedge config_serial_clock) disable iff (frame_clr_ff)
      byte_full && addr_phase_ff && !addr_match |=> !ack_oe_ff;
  endproperty
  a_ack_foreign: assert property (p_ack_foreign) else $error("Foreign address acknowledged");

endmodule : clock_fanout_output_enable_control

// ### bench/serial_host_model.sv
// Serial host model that writes the address byte and three configuration bytes
`timescale 1ns/1ps
module serial_host_model #(
  parameter realtime HALF_NS = 62.5
) (
  output logic link_clk,
  output logic data_pull,
  input wire logic data_line
);
  // Clock parks high between frames, data released to the pull-up
  initial begin
    link_clk = 1'b1;
    data_pull = 1'b0;
  end

  // Data moves a little after each falling edge, never while the clock is high
  task automatic put_bit(input logic b);
    #20;
    data_pull = ~b;
    #(HALF_NS - 20);
    link_clk = 1'b1;
    #HALF_NS;
    link_clk = 1'b0;
  endtask : put_bit

  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    #20;
    data_pull = 1'b0;
    #(HALF_NS - 20);
    link_clk = 1'b1;
    #(HALF_NS / 2);
    ack = ~data_line;
    #(HALF_NS / 2);
    link_clk = 1'b0;
  endtask : put_byte

  task automatic write_frame(input logic [7:0] addr, input logic [7:0] b0, input logic [7:0] b1,
                             input logic [7:0] b2, output logic [3:0] acks);
    // Start and stop get long holds so the main-clock framing sees them
    data_pull = 1'b1;
    #250;
    link_clk = 1'b0;
    #250;
    put_byte(addr, acks[3]);
    put_byte(b0, acks[2]);
    put_byte(b1, acks[1]);
    put_byte(b2, acks[0]);
    #20;
    data_pull = 1'b1;
    #(HALF_NS - 20);
    link_clk = 1'b1;
    #250;
    data_pull = 1'b0;
    #250;
  endtask : write_frame
endmodule : serial_host_model

// ### bench/clock_fanout_output_enable_control_tb_top.sv
// Testbench for the clock fan-out block with serially written output enables
`timescale 1ns/1ps
module clock_fanout_output_enable_control_tb_top;
  logic clock;
  logic rst;
  logic buf_in;
  logic out_drive_en;
  logic link_clk;
  logic data_pull;
  wire logic data_line;
  logic data_out;
  logic data_oe;
  logic [13:0] clk_out;
  logic [13:0] clk_out_oe;
  int errors;
  int n_checks;

  // Open-drain line with pull-up: low if either party pulls it
  assign data_line = ~(data_pull | (data_oe & ~data_out));

  clock_fanout_output_enable_control #(.NUM_OUT(14)) dut (
    .clock(clock),
    .rst(rst),
    .buf_in(buf_in),
    .out_drive_en(out_drive_en),
    .config_serial_clock(link_clk),
    .config_serial_data_in(data_line),
    .config_serial_data_out(data_out),
    .config_serial_data_oe(data_oe),
    .clk_out(clk_out),
    .clk_out_oe(clk_out_oe)
  );

  serial_host_model #(.HALF_NS(62.5)) host (
    .link_clk(link_clk),
    .data_pull(data_pull),
    .data_line(data_line)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Fanned-out clock, unrelated in phase to the main clock
  initial begin
    buf_in = 1'b0;
    #7;
    forever #15 buf_in = ~buf_in;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic [13:0] map_en(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    return {b2[7:6], b1[7:4], b1[1:0], b0[7:6], b0[3:0]};
  endfunction : map_en

  // Enabled outputs copy buf_in, disabled ones stay low in both phases
  task automatic check_outputs(input logic [13:0] exp);
    @(posedge buf_in);
    #7;
    chk({2'h0, clk_out}, {2'h0, exp});
    chk({2'h0, clk_out_oe}, 16'h3FFF);
    @(negedge buf_in);
    #7;
    chk({2'h0, clk_out}, 16'h0000);
  endtask : check_outputs

  task automatic t_drive_enable();
    @(posedge clock);
    #1;
    out_drive_en = 1'b0;
    repeat (4) @(posedge clock);
    chk({2'h0, clk_out_oe}, 16'h0000);
    #1;
    out_drive_en = 1'b1;
    repeat (4) @(posedge clock);
    check_outputs(14'h3FFF);
  endtask : t_drive_enable

  task automatic t_patterns();
    logic [7:0] pat [4][3];
    logic [3:0] acks;
    // Reserved bits are always written as zero
    pat = '{'{8'h4A, 8'h91, 8'h80}, '{8'h85, 8'h62, 8'h40}, '{8'h00, 8'h00, 8'h00}, '{8'hCF, 8'hF3, 8'hC0}};
    for (int p = 0; p < 4; p++) begin
      host.write_frame({7'h69, 1'b0}, pat[p][0], pat[p][1], pat[p][2], acks);
      chk({12'h000, acks}, 16'h000F);
      repeat (10) @(posedge clock);
      check_outputs(map_en(pat[p][0], pat[p][1], pat[p][2]));
    end
  endtask : t_patterns

  task automatic t_wrong_addr();
    logic [3:0] acks;
    host.write_frame({7'h69, 1'b0}, 8'h4A, 8'h91, 8'h80, acks);
    repeat (10) @(posedge clock);
    host.write_frame({7'h68, 1'b0}, 8'h00, 8'h00, 8'h00, acks);
    chk({12'h000, acks}, 16'h0000);
    host.write_frame({7'h69, 1'b1}, 8'h00, 8'h00, 8'h00, acks);
    chk({12'h000, acks}, 16'h0000);
    repeat (10) @(posedge clock);
    check_outputs(map_en(8'h4A, 8'h91, 8'h80));
  endtask : t_wrong_addr

  // Watchdog against a hung run
  initial begin
    #2_000_000;
    errors++;
    report_and_stop();
  end

  initial begin
    errors = 0;
    n_checks = 0;
    rst = 1'b1;
    out_drive_en = 1'b1;
    repeat (8) @(posedge clock);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clock);
    check_outputs(14'h3FFF);
    t_drive_enable();
    t_patterns();
    t_wrong_addr();
    report_and_stop();
  end
endmodule : clock_fanout_output_enable_control_tb_top
